// ### core/dpg_port.sv
/*
 Two multiplexed control pins usable as general purpose I/O, the thermal
 pull-down, the interrupt output and the low input-supply monitor.
 Assumes register accesses arrive from the serial decoder as one-cycle
 strobes; pin inputs and the comparator outputs are synchronous.
*/
`timescale 1ns/100ps
module dpg_port
(
    input wire logic clock,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_sel,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic cfg_pin_b_tx_mode,
    input wire logic thermal_fault_flag,
    input wire logic thermistor_comparator,
    input wire logic supply_below_thr,
    input wire logic supply_fault_clear,
    input wire logic sync_torch_pin_a_in,
    output logic sync_torch_pin_a_out,
    output logic sync_torch_pin_a_oe,
    input wire logic sync_volt_pin_b_in,
    output logic sync_volt_pin_b_out,
    output logic sync_volt_pin_b_oe,
    output logic pin_a_reset_n,
    output logic pin_b_tx_mode,
    output logic pin_b_sense,
    output logic monitor_enable,
    output logic [1:0] monitor_threshold,
    output logic supply_fault_flag
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic a_gpio;
        logic a_dir;
        logic a_data;
        logic b_gpio;
        logic b_dir;
        logic b_data;
        logic therm;
        logic mon_en;
        logic [1:0] thr;
        logic fault;
        logic [7:0] rdata;
    } dpg_state_t;

    dpg_state_t st;
    dpg_state_t next_st;
    logic [7:0] pin_view;
    logic [7:0] mon_view;

    always_comb
    begin
        pin_view = dpg_pkg::DPG_PF_FIXED_ONES;
        pin_view[dpg_pkg::DPG_PF_A_GPIO] = st.a_gpio;
        pin_view[dpg_pkg::DPG_PF_A_DIR] = st.a_dir;
        // Input reads the pin, output reads the latch
        pin_view[dpg_pkg::DPG_PF_A_DATA] = st.a_dir ? st.a_data
                                         : sync_torch_pin_a_in;
        pin_view[dpg_pkg::DPG_PF_B_GPIO] = st.b_gpio;
        pin_view[dpg_pkg::DPG_PF_B_DIR] = st.b_dir;
        pin_view[dpg_pkg::DPG_PF_B_DATA] = st.b_dir ? st.b_data
                                         : sync_volt_pin_b_in;
        pin_view[dpg_pkg::DPG_PF_THERM] = st.therm;
        mon_view = dpg_pkg::DPG_MON_FIXED_ONES;
        mon_view[dpg_pkg::DPG_MON_EN] = st.mon_en;
        mon_view[dpg_pkg::DPG_MON_THR_HI:dpg_pkg::DPG_MON_THR_LO] = st.thr;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        if (reg_wr && reg_sel == dpg_pkg::DPG_SEL_PIN)
        begin
            next_st.a_gpio = reg_wdata[dpg_pkg::DPG_PF_A_GPIO];
            next_st.a_dir = reg_wdata[dpg_pkg::DPG_PF_A_DIR];
            next_st.a_data = reg_wdata[dpg_pkg::DPG_PF_A_DATA];
            next_st.b_gpio = reg_wdata[dpg_pkg::DPG_PF_B_GPIO];
            next_st.b_dir = reg_wdata[dpg_pkg::DPG_PF_B_DIR];
            next_st.b_data = reg_wdata[dpg_pkg::DPG_PF_B_DATA];
            next_st.therm = reg_wdata[dpg_pkg::DPG_PF_THERM];
        end
        if (reg_wr && reg_sel == dpg_pkg::DPG_SEL_MON)
        begin
            next_st.mon_en = reg_wdata[dpg_pkg::DPG_MON_EN];
            next_st.thr = reg_wdata[dpg_pkg::DPG_MON_THR_HI:
                                    dpg_pkg::DPG_MON_THR_LO];
        end
        // Set wins over clear
        if (supply_fault_clear)
            next_st.fault = 1'b0;
        if (st.mon_en && supply_below_thr)
            next_st.fault = 1'b1;
        if (reg_rd)
            next_st.rdata = (reg_sel == dpg_pkg::DPG_SEL_MON) ? mon_view
                          : pin_view;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    logic b_out_gpio;
    logic b_pull;
    logic b_irq;

    assign reg_rdata = st.rdata;
    assign pin_a_reset_n = st.a_gpio ? 1'b1 : sync_torch_pin_a_in;
    assign sync_torch_pin_a_oe = st.a_gpio && st.a_dir;
    assign sync_torch_pin_a_out = st.a_data;
    assign b_out_gpio = st.b_gpio && st.b_dir;
    assign b_pull = b_out_gpio && st.therm && thermal_fault_flag;
    // Interrupt output drives the thermistor comparator when not a GPIO output
    assign b_irq = st.therm && !b_out_gpio;
    assign sync_volt_pin_b_oe = b_out_gpio || b_irq;
    assign sync_volt_pin_b_out = b_irq ? thermistor_comparator
                               : (st.b_data && !b_pull);
    assign pin_b_tx_mode = !st.b_gpio && !st.therm
                           && cfg_pin_b_tx_mode;
    assign pin_b_sense = sync_volt_pin_b_in;
    assign monitor_enable = st.mon_en;
    assign monitor_threshold = st.thr;
    assign supply_fault_flag = st.fault;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_pin_a_mode;
        @(posedge clock) disable iff (rst)
        !st.a_gpio |-> (pin_a_reset_n == sync_torch_pin_a_in)
                       && !sync_torch_pin_a_oe;
    endproperty
    a_pin_a_mode: assert property (p_pin_a_mode)
        else $error("pin A not reset input");

    property p_pin_a_out;
        @(posedge clock) disable iff (rst)
        reg_wr && reg_sel == dpg_pkg::DPG_SEL_PIN
        && reg_wdata[dpg_pkg::DPG_PF_A_GPIO]
        && reg_wdata[dpg_pkg::DPG_PF_A_DIR]
        |=> sync_torch_pin_a_oe
            && sync_torch_pin_a_out
               == $past(reg_wdata[dpg_pkg::DPG_PF_A_DATA]);
    endproperty
    a_pin_a_out: assert property (p_pin_a_out)
        else $error("pin A output wrong");

    property p_pin_b_cfg;
        @(posedge clock) disable iff (rst)
        st.b_gpio |-> !pin_b_tx_mode;
    endproperty
    a_pin_b_cfg: assert property (p_pin_b_cfg)
        else $error("pin B config leak");

    property p_pin_b_out;
        @(posedge clock) disable iff (rst)
        reg_wr && reg_sel == dpg_pkg::DPG_SEL_PIN
        && reg_wdata[dpg_pkg::DPG_PF_B_GPIO]
        && reg_wdata[dpg_pkg::DPG_PF_B_DIR]
        |=> sync_volt_pin_b_oe;
    endproperty
    a_pin_b_out: assert property (p_pin_b_out)
        else $error("pin B not driven");

    property p_pull;
        @(posedge clock) disable iff (rst)
        b_out_gpio && st.therm && thermal_fault_flag
        |-> sync_volt_pin_b_oe && !sync_volt_pin_b_out;
    endproperty
    a_pull: assert property (p_pull)
        else $error("pin B not pulled low");

    property p_irq;
        @(posedge clock) disable iff (rst)
        st.therm && !b_out_gpio
        |-> sync_volt_pin_b_oe
            && sync_volt_pin_b_out == thermistor_comparator;
    endproperty
    a_irq: assert property (p_irq)
        else $error("pin B interrupt wrong");

    property p_mon;
        @(posedge clock) disable iff (rst)
        reg_wr && reg_sel == dpg_pkg::DPG_SEL_MON
        |=> monitor_enable == $past(reg_wdata[dpg_pkg::DPG_MON_EN])
            && monitor_threshold == $past(reg_wdata[dpg_pkg::DPG_MON_THR_HI:
                                       dpg_pkg::DPG_MON_THR_LO]);
    endproperty
    a_mon: assert property (p_mon)
        else $error("monitor setting lost");

    property p_fault;
        @(posedge clock) disable iff (rst)
        monitor_enable && supply_below_thr |=> supply_fault_flag;
    endproperty
    a_fault: assert property (p_fault)
        else $error("supply fault not set");

    property p_fixed;
        @(posedge clock) disable iff (rst)
        reg_rd |=> reg_rdata[7] && ($past(reg_sel) == dpg_pkg::DPG_SEL_PIN
                   || reg_rdata[7:3] == 5'h1E);
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed bits wrong");
endmodule // dpg_port

// ### core/dpg_pkg.sv
/*
 Constants for the dual-pin general purpose port and supply monitor.
 Assumes an 8-bit register port driven by the device's serial decoder.
*/
package dpg_pkg;
    // ------------------------------------------------------------
    // Register selection
    // ------------------------------------------------------------
    localparam logic DPG_SEL_PIN = 1'b0;
    localparam logic DPG_SEL_MON = 1'b1;
    // ------------------------------------------------------------
    // Pin-function register fields
    // ------------------------------------------------------------
    localparam int DPG_PF_A_GPIO = 0;
    localparam int DPG_PF_A_DIR = 1;
    localparam int DPG_PF_A_DATA = 2;
    localparam int DPG_PF_B_GPIO = 3;
    localparam int DPG_PF_B_DIR = 4;
    localparam int DPG_PF_B_DATA = 5;
    localparam int DPG_PF_THERM = 6;
    localparam logic [7:0] DPG_PF_FIXED_ONES = 8'h80;
    // ------------------------------------------------------------
    // Supply monitor register fields
    // ------------------------------------------------------------
    localparam int DPG_MON_EN = 0;
    localparam int DPG_MON_THR_LO = 1;
    localparam int DPG_MON_THR_HI = 2;
    localparam logic [7:0] DPG_MON_FIXED_ONES = 8'hF0;
    localparam logic [1:0] DPG_THR_RESET = 2'h0;
endpackage

// ### verif/dpg_pin_model.sv
/*
 Host-side pin drivers for the two multiplexed pins.
 Assumes the block's pin outputs and enables; returns resolved pin levels.
*/
`timescale 1ns/100ps
module dpg_pin_model
(
    input wire logic ext_a,
    input wire logic ext_b,
    input wire logic out_a,
    input wire logic oe_a,
    input wire logic out_b,
    input wire logic oe_b,
    output logic in_a,
    output logic in_b
);
    // ------------------------------------------------------------
    // Wire resolution: the block wins while it drives
    // ------------------------------------------------------------
    assign in_a = oe_a ? out_a : ext_a;
    assign in_b = oe_b ? out_b : ext_b;
endmodule // dpg_pin_model

// ### verif/dual_pin_gpio_and_supply_monitor_tb.sv
/*
 Self-checking bench for the pin port and supply monitor.
 Assumes one-cycle register strobes and answers one cycle later.
*/
`timescale 1ns/100ps
module dual_pin_gpio_and_supply_monitor_tb;
    logic clock, rst, reg_wr, reg_rd, reg_sel, cfg_pin_b_tx_mode, ext_a, ext_b;
    logic thermal_fault_flag, thermistor_comparator, supply_below_thr;
    logic supply_fault_clear, pin_a_reset_n, pin_b_tx_mode, pin_b_sense;
    logic sync_torch_pin_a_in, sync_torch_pin_a_out, sync_torch_pin_a_oe;
    logic sync_volt_pin_b_in, sync_volt_pin_b_out, sync_volt_pin_b_oe;
    logic monitor_enable, supply_fault_flag;
    logic [1:0] monitor_threshold;
    logic [7:0] reg_wdata, reg_rdata, rd_data;
    int fail_count = 0;
    int checks = 0;
    dpg_port u_dut (.clock, .rst, .reg_wr, .reg_rd, .reg_sel, .reg_wdata,
        .reg_rdata, .cfg_pin_b_tx_mode, .thermal_fault_flag,
        .thermistor_comparator, .supply_below_thr, .supply_fault_clear,
        .sync_torch_pin_a_in, .sync_torch_pin_a_out, .sync_torch_pin_a_oe,
        .sync_volt_pin_b_in, .sync_volt_pin_b_out, .sync_volt_pin_b_oe,
        .pin_a_reset_n, .pin_b_tx_mode, .pin_b_sense, .monitor_enable,
        .monitor_threshold, .supply_fault_flag);
    dpg_pin_model u_pins (.ext_a, .ext_b, .out_a(sync_torch_pin_a_out),
        .oe_a(sync_torch_pin_a_oe), .out_b(sync_volt_pin_b_out),
        .oe_b(sync_volt_pin_b_oe), .in_a(sync_torch_pin_a_in),
        .in_b(sync_volt_pin_b_in));
    // ------------------------------------------------------------
    // Clock, register access and comparison tasks
    // ------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic wr(input logic sel, input logic [7:0] d);
        @(negedge clock);
        reg_wr = 1'b1;
        reg_sel = sel;
        reg_wdata = d;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic sel);
        @(negedge clock);
        reg_rd = 1'b1;
        reg_sel = sel;
        @(negedge clock);
        reg_rd = 1'b0;
        rd_data = reg_rdata;
    endtask
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(dpg_pkg::DPG_SEL_PIN);
        chk("pin reg", 8'h80, rd_data);
        rd(dpg_pkg::DPG_SEL_MON);
        chk("mon reg", 8'hF0, rd_data);
        chk("pin a reset", 8'h00, pin_a_reset_n);
    endtask
    task automatic t_pin_a;
        wr(dpg_pkg::DPG_SEL_PIN, 8'h87);
        chk("pin a out", 8'h03,
            {sync_torch_pin_a_oe, sync_torch_pin_a_out});
        chk("pin a reset", 8'h01, pin_a_reset_n);
        wr(dpg_pkg::DPG_SEL_PIN, 8'h01);
        ext_a = 1'b1;
        rd(dpg_pkg::DPG_SEL_PIN);
        chk("pin a in", 8'h85, rd_data);
    endtask
    task automatic t_pin_b;
        cfg_pin_b_tx_mode = 1'b1;
        ext_b = 1'b1;
        wr(dpg_pkg::DPG_SEL_PIN, 8'h00);
        chk("pin b tx", 8'h01, pin_b_tx_mode);
        chk("pin b sense", 8'h01, pin_b_sense);
        wr(dpg_pkg::DPG_SEL_PIN, 8'h38);
        chk("pin b out", 8'h03,
            {sync_volt_pin_b_oe, sync_volt_pin_b_out});
        thermal_fault_flag = 1'b1;
        wr(dpg_pkg::DPG_SEL_PIN, 8'h78);
        chk("pin b pull", 8'h02,
            {sync_volt_pin_b_oe, sync_volt_pin_b_out});
        chk("pin b tx off", 8'h00, pin_b_tx_mode);
        wr(dpg_pkg::DPG_SEL_PIN, 8'h38);
        chk("pin b no pull", 8'h03,
            {sync_volt_pin_b_oe, sync_volt_pin_b_out});
        thermistor_comparator = 1'b1;
        wr(dpg_pkg::DPG_SEL_PIN, 8'h40);
        chk("pin b irq", 8'h03,
            {sync_volt_pin_b_oe, sync_volt_pin_b_out});
        thermistor_comparator = 1'b0;
        @(negedge clock);
        chk("pin b irq low", 8'h02,
            {sync_volt_pin_b_oe, sync_volt_pin_b_out});
    endtask
    task automatic t_monitor;
        for (int t = 0; t < 4; t++)
        begin
            wr(dpg_pkg::DPG_SEL_MON, 8'hF9 | 8'(t << 1));
            rd(dpg_pkg::DPG_SEL_MON);
            chk("mon read", 8'hF1 | 8'(t << 1), rd_data);
            chk("mon thr", 8'(t), monitor_threshold);
            chk("mon en", 8'h01, monitor_enable);
        end
        wr(dpg_pkg::DPG_SEL_MON, 8'h00);
        chk("mon off", 8'h00, monitor_enable);
        supply_below_thr = 1'b1;
        @(negedge clock);
        chk("fault off", 8'h00, supply_fault_flag);
        wr(dpg_pkg::DPG_SEL_MON, 8'h01);
        @(negedge clock);
        chk("fault", 8'h01, supply_fault_flag);
        supply_fault_clear = 1'b1;
        @(negedge clock);
        chk("fault hold", 8'h01, supply_fault_flag);
        supply_below_thr = 1'b0;
        @(negedge clock);
        supply_fault_clear = 1'b0;
        chk("fault clr", 8'h00, supply_fault_flag);
    endtask
    initial
    begin
        {rst, reg_wr, reg_rd, reg_sel, reg_wdata, cfg_pin_b_tx_mode} = 13'h1000;
        {ext_a, ext_b, thermal_fault_flag, thermistor_comparator} = 4'h0;
        {supply_below_thr, supply_fault_clear} = 2'h0;
        repeat (12) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        t_reset();
        t_pin_a();
        t_pin_b();
        t_monitor();
        print_verdict();
    end
    initial
    begin
        #5000;
        fail_count++;
        print_verdict();
    end
endmodule // dual_pin_gpio_and_supply_monitor_tb
